// *** hppc_pkg.sv ***
/*
  Shared constants, types and register map of the hub downstream port power
  and charging controller. Assumes a 20 MHz system clock and four ports.
*/
package hppc_pkg;

  localparam int HPPC_NPORT = 4;
  localparam int HPPC_CLK_PERIOD_NS = 50;
  localparam int HPPC_CLK_MHZ = 20;

  // Strap pins are left undriven this long before they are sampled.
  localparam int HPPC_STRAP_NS = 1000;
  localparam int HPPC_STRAP_CYC = (HPPC_STRAP_NS + HPPC_CLK_PERIOD_NS - 1) / HPPC_CLK_PERIOD_NS;
  // Dwell of each step of the automatic charging sequence.
  localparam int HPPC_DWELL_US = 100000;
  localparam int HPPC_DWELL_CYC = HPPC_DWELL_US * HPPC_CLK_MHZ;

  // Word index of each register; byte address is four times the index.
  localparam logic [3:0] HPPC_CTRL_IDX = 4'h0;
  localparam logic [3:0] HPPC_STAT_IDX = 4'h1;
  localparam logic [3:0] HPPC_INT_IDX = 4'h2;
  localparam logic [3:0] HPPC_MASK_IDX = 4'h3;
  localparam logic [3:0] HPPC_CHG_IDX = 4'h4;

  localparam logic [31:0] HPPC_CTRL_RST = 32'h0000_0400;
  localparam logic [5:0] HPPC_INT_RST = 6'h00;
  localparam int HPPC_INT_W = 6;
  localparam int HPPC_INT_SEQ_BIT = 4;
  localparam int HPPC_INT_CONN_BIT = 5;

  // Charge selection used while the upstream port is not connected.
  localparam logic [2:0] HPPC_SEL_DCP = 3'h0;
  localparam logic [2:0] HPPC_SEL_DIV1 = 3'h1;
  localparam logic [2:0] HPPC_SEL_DIV2 = 3'h2;
  localparam logic [2:0] HPPC_SEL_DIV3 = 3'h3;
  localparam logic [2:0] HPPC_SEL_AUTO = 3'h4;

  typedef enum logic [1:0] {
    HPPC_SPD_SS,
    HPPC_SPD_HS,
    HPPC_SPD_FS,
    HPPC_SPD_LS
  } hppc_speed_e;

  typedef enum logic [2:0] {
    HPPC_CHG_OFF,
    HPPC_CHG_CDP,
    HPPC_CHG_DCP,
    HPPC_CHG_DIV1,
    HPPC_CHG_DIV2,
    HPPC_CHG_DIV3
  } hppc_chg_e;

  typedef enum logic {
    HPPC_ST_STRAP,
    HPPC_ST_RUN
  } hppc_state_e;

  // Layout of the control register.
  typedef struct packed {
    logic [20:0] rsvd_hi;
    logic [2:0] chg_sel;
    logic [2:0] rsvd_lo;
    logic ganged;
    logic [3:0] pwr_req;
  } hppc_ctrl_s;

endpackage

// *** hppc_sync2.sv ***
/*
  Two-stage level synchroniser for a vector of asynchronous inputs.
  Assumes one clock and a synchronous active-high reset; resets to all ones,
  which is the idle level of active-low fault inputs.
*/
`timescale 1ns/1ps
module hppc_sync2 import hppc_pkg::*; #(
  parameter int W = HPPC_NPORT
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Only the second stage is read outside; the first may be metastable.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          meta_ff[g] <= 1'b1;
          sync_ff[g] <= 1'b1;
        end else begin
          meta_ff[g] <= async_i[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_ff;

endmodule

// *** hppc_top.sv ***
/*
  Downstream port power and charging controller of a four-port hub, with an
  Avalon-MM register slave and one level interrupt.
  Assumes one 20 MHz clock, inputs synchronous to it except the fault inputs,
  which are synchronised here, and an external pad that resolves each strap pin
  from its output and output enable.
*/
`timescale 1ns/1ps
module hppc_top import hppc_pkg::*; #(
  parameter int DWELL_CYC = HPPC_DWELL_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic up_connected_i,
  input wire hppc_speed_e up_speed_i,
  input wire logic [3:0] port_power_on_charge_strap_i,
  output logic [3:0] port_power_on_charge_strap_o,
  output logic [3:0] port_power_on_charge_strap_oe_o,
  input wire logic [3:0] overcurrent_inputs_n_i,
  output logic ds_ss_en_o,
  output logic ds_hs_en_o,
  output logic [3:0][2:0] chg_mode_o,
  output logic irq_o
);

  logic [3:0] oc_n_sync;
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  hppc_ctrl_s ctrl;
  hppc_state_e st_ff;
  logic [4:0] strap_cnt_ff;
  logic [3:0] strap_ff;
  logic [3:0] trip_ff;
  logic [3:0] nxt_trip;
  logic [3:0] pwr_ff;
  logic [3:0] pwr_want;
  logic [3:0] oe_ff;
  logic [3:0] oc_act;
  logic [3:0] oc_prev_ff;
  logic [3:0] oc_evt;
  logic ss_en_ff;
  logic hs_en_ff;
  logic [3:0][2:0] chg_ff;
  logic [3:0][2:0] nxt_chg;
  hppc_chg_e seq_ff;
  hppc_chg_e nxt_seq;
  hppc_chg_e uncon_mode;
  logic [21:0] dwell_ff;
  logic seq_run;
  logic seq_step;
  logic seq_done;
  logic conn_prev_ff;
  logic [HPPC_INT_W-1:0] int_ff;
  logic [HPPC_INT_W-1:0] mask_ff;
  logic [HPPC_INT_W-1:0] int_set;
  logic [HPPC_INT_W-1:0] int_clr;
  logic irq_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rdata_mux;
  logic [31:0] be_mask;
  logic acc;
  logic wr_ctrl;
  logic wr_int;
  logic wr_mask;
  logic run;
  logic any_req;
  logic slow_link;
  logic strap_done;

  // Fault inputs pass two flops before anything looks at them.
  hppc_sync2 #(.W(HPPC_NPORT)) u_oc_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(overcurrent_inputs_n_i),
    .sync_o(oc_n_sync)
  );

  // Bus decode: an access is completed on the cycle waitrequest is low.
  assign acc = (avs_read_i | avs_write_i) & wait_ff;
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wr_ctrl = avs_write_i & ~wait_ff & (avs_address_i == HPPC_CTRL_IDX);
  assign wr_int = avs_write_i & ~wait_ff & (avs_address_i == HPPC_INT_IDX);
  assign wr_mask = avs_write_i & ~wait_ff & (avs_address_i == HPPC_MASK_IDX);
  assign nxt_ctrl = (ctrl_ff & ~be_mask) | (avs_writedata_i & be_mask);
  assign ctrl = hppc_ctrl_s'(ctrl_ff);

  // Unmapped addresses read as zero and ignore writes.
  assign rdata_mux =
    (avs_address_i == HPPC_CTRL_IDX) ? ctrl_ff :
    (avs_address_i == HPPC_STAT_IDX) ? {16'h0000, strap_done, up_speed_i, up_connected_i,
                                        strap_ff, oc_act, pwr_ff} :
    (avs_address_i == HPPC_INT_IDX) ? {26'h0000000, int_ff} :
    (avs_address_i == HPPC_MASK_IDX) ? {26'h0000000, mask_ff} :
    (avs_address_i == HPPC_CHG_IDX) ? {20'h00000, chg_ff} : 32'h0000_0000;

  // One wait cycle per access keeps read data registered.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= ~acc;
      if (acc && avs_read_i) begin
        rdata_ff <= rdata_mux;
      end
    end
  end

  // Control and mask registers, byte-lane writable.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= HPPC_CTRL_RST;
      mask_ff <= HPPC_INT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl & 32'h0000_071f;
      end
      if (wr_mask && avs_byteenable_i[0]) begin
        mask_ff <= avs_writedata_i[HPPC_INT_W-1:0];
      end
    end
  end

  // Start-up: strap pins are inputs until sampled, then become power enables.
  assign strap_done = (st_ff == HPPC_ST_RUN);
  assign run = strap_done;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_ff <= HPPC_ST_STRAP;
      strap_cnt_ff <= 5'h00;
      strap_ff <= 4'h0;
      oe_ff <= 4'h0;
    end else begin
      case (st_ff)
        HPPC_ST_STRAP: begin
          strap_cnt_ff <= strap_cnt_ff + 5'h01;
          if (strap_cnt_ff == 5'(HPPC_STRAP_CYC - 1)) begin
            strap_ff <= port_power_on_charge_strap_i;
            oe_ff <= 4'hf;
            st_ff <= HPPC_ST_RUN;
          end
        end
        HPPC_ST_RUN: begin
          oe_ff <= 4'hf;
        end
        default: begin
          st_ff <= HPPC_ST_STRAP;
        end
      endcase
    end
  end

  // Fault level and trip latches; a trip holds until the request is dropped.
  assign oc_act = ~oc_n_sync & {4{run}};
  assign oc_evt = oc_act & ~oc_prev_ff;
  assign any_req = |ctrl.pwr_req;
  assign nxt_trip = ctrl.ganged ?
    ((|oc_act) | ((|trip_ff) & any_req) ? 4'hf : 4'h0) :
    (oc_act | (trip_ff & ctrl.pwr_req));
  // Ganged power follows any request and drops when none remain or on a trip.
  assign pwr_want = ctrl.ganged ? {4{any_req & ~(|nxt_trip)}} :
                    (ctrl.pwr_req & ~nxt_trip);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      trip_ff <= 4'h0;
      pwr_ff <= 4'h0;
      oc_prev_ff <= 4'h0;
    end else begin
      trip_ff <= nxt_trip;
      oc_prev_ff <= oc_act;
      pwr_ff <= run ? pwr_want : 4'h0;
    end
  end

  // Speed restriction follows the upstream link.
  assign slow_link = (up_speed_i == HPPC_SPD_FS) | (up_speed_i == HPPC_SPD_LS);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ss_en_ff <= 1'b0;
      hs_en_ff <= 1'b0;
    end else begin
      ss_en_ff <= run & ~slow_link & (up_speed_i != HPPC_SPD_HS);
      hs_en_ff <= run & ~slow_link;
    end
  end

  // Automatic sequence runs only unconnected with auto selected; it restarts
  // at divider three whenever that stops holding, and rests in DCP.
  assign seq_run = ~up_connected_i & (ctrl.chg_sel == HPPC_SEL_AUTO) & (|(pwr_ff & strap_ff));
  assign seq_step = seq_run & (seq_ff != HPPC_CHG_DCP) & (dwell_ff == 22'(DWELL_CYC - 1));
  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      HPPC_CHG_DIV3: nxt_seq = HPPC_CHG_DIV2;
      HPPC_CHG_DIV2: nxt_seq = HPPC_CHG_DIV1;
      HPPC_CHG_DIV1: nxt_seq = HPPC_CHG_DCP;
      default: nxt_seq = HPPC_CHG_DCP;
    endcase
  end
  assign seq_done = seq_step & (nxt_seq == HPPC_CHG_DCP);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !seq_run) begin
      seq_ff <= HPPC_CHG_DIV3;
      dwell_ff <= 22'h000000;
    end else if (seq_step) begin
      seq_ff <= nxt_seq;
      dwell_ff <= 22'h000000;
    end else if (seq_ff != HPPC_CHG_DCP) begin
      dwell_ff <= dwell_ff + 22'h000001;
    end
  end

  // Fixed selections; the auto case takes the sequencer's step.
  assign uncon_mode =
    (ctrl.chg_sel == HPPC_SEL_AUTO) ? seq_ff :
    (ctrl.chg_sel == HPPC_SEL_DIV1) ? HPPC_CHG_DIV1 :
    (ctrl.chg_sel == HPPC_SEL_DIV2) ? HPPC_CHG_DIV2 :
    (ctrl.chg_sel == HPPC_SEL_DIV3) ? HPPC_CHG_DIV3 : HPPC_CHG_DCP;

  // Per-port charge mode: only strapped, powered ports charge at all.
  genvar p;
  generate
    for (p = 0; p < HPPC_NPORT; p++) begin : g_port
      assign nxt_chg[p] = (!strap_ff[p] || !pwr_want[p] || !run) ? HPPC_CHG_OFF :
                          up_connected_i ? HPPC_CHG_CDP : uncon_mode;
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      chg_ff <= {4{HPPC_CHG_OFF}};
    end else begin
      chg_ff <= nxt_chg;
    end
  end

  // Sticky status: hardware set wins over a write-one clear in the same cycle.
  assign int_set = {(up_connected_i != conn_prev_ff) & run, seq_done, oc_evt};
  assign int_clr = (wr_int && avs_byteenable_i[0]) ? avs_writedata_i[HPPC_INT_W-1:0] :
                   {HPPC_INT_W{1'b0}};
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      int_ff <= HPPC_INT_RST;
      conn_prev_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      int_ff <= (int_ff & ~int_clr) | int_set;
      conn_prev_ff <= up_connected_i;
      irq_ff <= |(((int_ff & ~int_clr) | int_set) & mask_ff);
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign port_power_on_charge_strap_o = pwr_ff;
  assign port_power_on_charge_strap_oe_o = oe_ff;
  assign ds_ss_en_o = ss_en_ff;
  assign ds_hs_en_o = hs_en_ff;
  assign chg_mode_o = chg_ff;
  assign irq_o = irq_ff;

  // Checks on the behaviour above.
  slow_link_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    slow_link |=> (!ds_ss_en_o && !ds_hs_en_o))
    else $error("fast downstream speed left on behind a slow upstream link");

  indiv_pwr_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (run && !ctrl.ganged && !(|oc_act) && !(|trip_ff)) |=> (pwr_ff == $past(ctrl.pwr_req)))
    else $error("individual port power does not follow the request");

  oc_isolate_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (run && !ctrl.ganged && oc_act[0] && !(|oc_act[3:1]) && !(|trip_ff))
      |=> (!pwr_ff[0] && pwr_ff[3:1] == $past(ctrl.pwr_req[3:1])))
    else $error("over-current did not isolate only its own port");

  ganged_on_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (run && ctrl.ganged && any_req && !(|oc_act) && !(|trip_ff)) |=> (pwr_ff == 4'hf))
    else $error("ganged power not applied to all ports");

  ganged_oc_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ctrl.ganged && (|oc_act)) |=> (pwr_ff == 4'h0) [*2])
    else $error("ganged over-current did not remove all power");

  cdp_conn_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (run && up_connected_i && strap_ff[1] && pwr_want[1]) |=> (chg_mode_o[1] == HPPC_CHG_CDP))
    else $error("connected charging port not in CDP");

  seq_start_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ($rose(seq_run)) |-> (seq_ff == HPPC_CHG_DIV3 && dwell_ff == 22'h000000))
    else $error("automatic sequence did not start at divider three");

  seq_end_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (seq_ff == HPPC_CHG_DCP && seq_run) |=> (seq_ff == HPPC_CHG_DCP))
    else $error("automatic sequence left DCP while still running");

  reset_quiet_a: assert property (
    @(posedge sys_clk_i)
    rst_i |=> (pwr_ff == 4'h0 && oe_ff == 4'h0 && !irq_o && chg_ff == {4{HPPC_CHG_OFF}}))
    else $error("outputs active during reset");

  strap_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !strap_done |-> (port_power_on_charge_strap_oe_o == 4'h0 && pwr_ff == 4'h0))
    else $error("power enabled before strap sampling finished");

endmodule

// *** hppc_port_model.sv ***
/*
  Board-side model of the four downstream power switches and their straps.
  Assumes the controller drives each strap pin only while its enable is high.
*/
`timescale 1ns/1ps
module hppc_port_model import hppc_pkg::*; (
  input wire logic [3:0] pwr_en_i,
  input wire logic [3:0] pwr_oe_i,
  input wire logic [3:0] strap_cfg_i,
  input wire logic [3:0] fault_i,
  output logic [3:0] pin_o,
  output logic [3:0] overcurrent_n_o
);
  // Released strap pins fall to the board strap level, set by its resistor.
  assign pin_o = (pwr_oe_i & pwr_en_i) | (~pwr_oe_i & strap_cfg_i);
  // Fault lines idle high and are pulled low by a tripped switch only.
  assign overcurrent_n_o = ~fault_i;
endmodule

// *** tb_top.sv ***
/*
  Self-checking bench of the port power and charging controller.
  Assumes the board model resolves strap pins and the design runs at 20 MHz.
*/
`timescale 1ns/1ps
module tb_top import hppc_pkg::*; ;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic up_conn = 1'b1;
  hppc_speed_e up_speed = HPPC_SPD_SS;
  logic [3:0] strap_cfg = 4'h3;
  logic [3:0] fault = 4'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic irq;
  logic ss_en;
  logic hs_en;
  logic [3:0] pin_o;
  logic [3:0] pin_oe;
  logic [3:0] pin_i;
  logic [3:0] oc_n;
  logic [3:0][2:0] chg;
  logic [31:0] rv;
  int mismatches = 0;
  int total_checks = 0;

  hppc_top #(.DWELL_CYC(8)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .up_connected_i(up_conn),
    .up_speed_i(up_speed), .port_power_on_charge_strap_i(pin_i),
    .port_power_on_charge_strap_o(pin_o), .port_power_on_charge_strap_oe_o(pin_oe),
    .overcurrent_inputs_n_i(oc_n), .ds_ss_en_o(ss_en), .ds_hs_en_o(hs_en),
    .chg_mode_o(chg), .irq_o(irq)
  );

  hppc_port_model u_ports (
    .pwr_en_i(pin_o), .pwr_oe_i(pin_oe), .strap_cfg_i(strap_cfg), .fault_i(fault),
    .pin_o(pin_i), .overcurrent_n_o(oc_n)
  );

  // Free-running system clock.
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic final_report;
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // One Avalon access; the request is held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk("bus wait", 32'h0, 32'h1);
      final_report();
    end
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Reset, then the strap phase; each is checked quiet once, then the sampled straps are read back.
  task automatic t_reset;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    cyc(8);
    chk("reset quiet", 32'h0080_0000, {waitreq, irq, ss_en, hs_en, pin_o, pin_oe, chg});
    cyc(8);
    rst_i <= 1'b0;
    cyc(10);
    chk("strap phase", 32'h0, {pin_o, pin_oe});
    cyc(15);
    chk("pin role", 32'hf, pin_oe);
    bus(1'b0, HPPC_STAT_IDX, 32'h0);
    chk("status straps", 32'h8300, rv & 32'h8f00);
    bus(1'b0, 4'hf, 32'h0);
    chk("unmapped read", 32'h0, rv);
  endtask

  // Every upstream speed against the downstream speed enables.
  task automatic t_speed;
    logic [1:0] exp;
    for (int i = 0; i < 4; i++) begin
      up_speed <= hppc_speed_e'(i);
      cyc(4);
      exp = (i == 0) ? 2'b11 : (i == 1) ? 2'b01 : 2'b00;
      chk("speed enables", 32'(exp), 32'({ss_en, hs_en}));
    end
    up_speed <= HPPC_SPD_SS;
  endtask

  // Individual switching: a trip on port 0 leaves port 2 alone.
  task automatic t_indiv;
    bus(1'b1, HPPC_MASK_IDX, 32'h1);
    bus(1'b1, HPPC_CTRL_IDX, 32'h405);
    cyc(2);
    chk("indiv power", 32'h5, pin_o);
    fault[0] <= 1'b1;
    cyc(1);
    chk("sync delay", 32'h5, pin_o);
    cyc(4);
    chk("indiv trip", 32'h4, pin_o);
    chk("irq set", 32'h1, irq);
    fault[0] <= 1'b0;
    bus(1'b1, HPPC_INT_IDX, 32'h1);
    cyc(2);
    chk("irq clear", 32'h0, irq);
    chk("trip holds", 32'h4, pin_o);
    bus(1'b1, HPPC_CTRL_IDX, 32'h404);
    bus(1'b1, HPPC_CTRL_IDX, 32'h405);
    cyc(2);
    chk("power back", 32'h5, pin_o);
  endtask

  // Ganged switching; only port 0 carries the shared switch fault line.
  task automatic t_ganged;
    bus(1'b1, HPPC_CTRL_IDX, 32'h411);
    cyc(2);
    chk("ganged on", 32'hf, pin_o);
    bus(1'b1, HPPC_CTRL_IDX, 32'h412);
    cyc(2);
    chk("ganged held", 32'hf, pin_o);
    bus(1'b1, HPPC_CTRL_IDX, 32'h410);
    cyc(2);
    chk("ganged off", 32'h0, pin_o);
    bus(1'b1, HPPC_CTRL_IDX, 32'h412);
    cyc(2);
    fault[0] <= 1'b1;
    cyc(5);
    chk("ganged trip", 32'h0, pin_o);
    fault[0] <= 1'b0;
    bus(1'b1, HPPC_CTRL_IDX, 32'h410);
    bus(1'b1, HPPC_INT_IDX, 32'h1);
  endtask

  // Waits, bounded, for port 0 to show the given charge mode.
  task automatic wait_mode(input hppc_chg_e m);
    int n;
    n = 0;
    while (chg[0] !== m && n < 100) begin
      cyc(1);
      n++;
    end
    chk("auto step", 32'(m), 32'(chg[0]));
    if (n >= 100) begin
      final_report();
    end
  endtask

  // Charging modes: CDP when connected, DCP and the divider walk when not.
  task automatic t_charge;
    hppc_chg_e dm;
    bus(1'b1, HPPC_CTRL_IDX, 32'h00f);
    cyc(3);
    chk("cdp", 32'({HPPC_CHG_OFF, HPPC_CHG_OFF, HPPC_CHG_CDP, HPPC_CHG_CDP}), 32'(chg));
    up_conn <= 1'b0;
    cyc(3);
    chk("dcp", 32'({HPPC_CHG_OFF, HPPC_CHG_OFF, HPPC_CHG_DCP, HPPC_CHG_DCP}), 32'(chg));
    // Fixed divider selections, walked downwards so that the automatic run
    // below must visibly start again at divider three.
    for (int s = 3; s > 0; s--) begin
      bus(1'b1, HPPC_CTRL_IDX, 32'h00f | (32'(s) << 8));
      cyc(2);
      dm = (s == 3) ? HPPC_CHG_DIV3 : (s == 2) ? HPPC_CHG_DIV2 : HPPC_CHG_DIV1;
      chk("divider", 32'({HPPC_CHG_OFF, HPPC_CHG_OFF, dm, dm}), 32'(chg));
    end
    bus(1'b1, HPPC_MASK_IDX, 32'h10);
    bus(1'b1, HPPC_CTRL_IDX, 32'h40f);
    wait_mode(HPPC_CHG_DIV3);
    wait_mode(HPPC_CHG_DIV2);
    wait_mode(HPPC_CHG_DIV1);
    wait_mode(HPPC_CHG_DCP);
    cyc(3);
    chk("seq irq", 32'h1, irq);
    bus(1'b0, HPPC_INT_IDX, 32'h0);
    chk("int events", 32'h30, rv & 32'h30);
    up_conn <= 1'b1;
  endtask

  // Main sequence, ending with a second reset in mid-run.
  initial begin
    t_reset();
    t_speed();
    t_indiv();
    t_ganged();
    t_charge();
    t_reset();
    bus(1'b0, HPPC_CTRL_IDX, 32'h0);
    chk("ctrl default", HPPC_CTRL_RST, rv);
    bus(1'b0, HPPC_INT_IDX, 32'h0);
    chk("int default", 32'h0, rv);
    final_report();
  end
endmodule
